// File: rtl/fcr_top.sv
// Purpose: coefficient register bank for the equalizer_fir filters
// Assumes: axi4-lite master, inputs synchronous to sys_clk_in
// Notes:   one write and one read in flight; unmapped words answer slverr
`timescale 1ns/1ps
`include "fcr_regs.svh"

// Functional notes
// - channel a tap nine holds signed 12-bit coefficient
// - first channel b register is b tap one
// - second channel b register is b tap two
// - third channel b register is b tap three
// - fourth channel b register is b tap four
// - readback shows coefficient msb as zero
// - registers reset zero; bits 15:12 writable
// - nine taps; center tap eighteen bits wide
module fcr_top
   import fcr_pkg::*;
(
   // clock, reset, enable
   input  wire logic                     sys_clk_in,
   input  wire logic                     rst_in,
   input  wire logic                     ce_in,
   // write address channel
   input  wire logic                     s_axi_awvalid_in,
   output logic                          s_axi_awready_out,
   input  wire logic [`FCR_ADDR_W-1:0]   s_axi_awaddr_in,
   input  wire logic [2:0]               s_axi_awprot_in,
   // write data channel
   input  wire logic                     s_axi_wvalid_in,
   output logic                          s_axi_wready_out,
   input  wire logic [`FCR_DATA_W-1:0]   s_axi_wdata_in,
   input  wire logic [`FCR_STRB_W-1:0]   s_axi_wstrb_in,
   // write response channel
   output logic                          s_axi_bvalid_out,
   input  wire logic                     s_axi_bready_in,
   output logic [1:0]                    s_axi_bresp_out,
   // read address channel
   input  wire logic                     s_axi_arvalid_in,
   output logic                          s_axi_arready_out,
   input  wire logic [`FCR_ADDR_W-1:0]   s_axi_araddr_in,
   input  wire logic [2:0]               s_axi_arprot_in,
   // read data channel
   output logic                          s_axi_rvalid_out,
   input  wire logic                     s_axi_rready_in,
   output logic [`FCR_DATA_W-1:0]        s_axi_rdata_out,
   output logic [1:0]                    s_axi_rresp_out,
   // filter side
   input  wire logic                     dual_mode_in,
   output fcr_coeff_bus_s                coeff_out
);

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam fcr_idx_t REG_IDX [`FCR_NUM_REGS] = '{
      `FCR_IDX_A_TAP9,
      `FCR_IDX_B_TAP1,
      `FCR_IDX_B_TAP2,
      `FCR_IDX_B_TAP3,
      `FCR_IDX_B_TAP4
   };

   // ----------------------------------------
   // write channel state
   // ----------------------------------------
   logic                      aw_got_r;
   logic                      w_got_r;
   fcr_idx_t                  aw_idx_r;
   fcr_reg_t                  w_data_r;
   logic [1:0]                w_strb_r;
   logic                      bvalid_r;
   logic [1:0]                bresp_r;

   // ----------------------------------------
   // read channel state
   // ----------------------------------------
   logic                      rvalid_r;
   logic [`FCR_DATA_W-1:0]    rdata_r;
   logic [1:0]                rresp_r;

   // ----------------------------------------
   // handshake decode
   // ----------------------------------------
   wire logic                 aw_hs;
   wire logic                 w_hs;
   wire logic                 ar_hs;
   wire logic                 b_hs;
   wire logic                 r_hs;
   wire logic                 do_write;
   wire fcr_idx_t             ar_idx;

   assign s_axi_awready_out = ce_in && !aw_got_r && !bvalid_r;
   assign s_axi_wready_out  = ce_in && !w_got_r && !bvalid_r;
   assign s_axi_arready_out = ce_in && !rvalid_r;

   assign aw_hs    = s_axi_awvalid_in && s_axi_awready_out;
   assign w_hs     = s_axi_wvalid_in && s_axi_wready_out;
   assign ar_hs    = s_axi_arvalid_in && s_axi_arready_out;
   assign b_hs     = ce_in && bvalid_r && s_axi_bready_in;
   assign r_hs     = ce_in && rvalid_r && s_axi_rready_in;
   assign do_write = ce_in && aw_got_r && w_got_r && !bvalid_r;
   assign ar_idx   = s_axi_araddr_in[`FCR_IDX_MSB:`FCR_IDX_LSB];

   // ----------------------------------------
   // per-register storage and decode
   // ----------------------------------------
   fcr_reg_t                  reg_val   [`FCR_NUM_REGS];
   logic [`FCR_DATA_W-1:0]    rd_view   [`FCR_NUM_REGS];
   logic [`FCR_NUM_REGS-1:0]  wr_hit;
   logic [`FCR_NUM_REGS-1:0]  rd_hit;

   genvar gi;
   generate
      for (gi = 0; gi < `FCR_NUM_REGS; gi++) begin : g_reg
         assign wr_hit[gi] = (aw_idx_r == REG_IDX[gi]);
         assign rd_hit[gi] = (ar_idx == REG_IDX[gi]);

         fcr_coeff_reg u_reg (
            .sys_clk_in (sys_clk_in),
            .rst_in     (rst_in),
            .ce_in      (ce_in),
            .we_in      (do_write && wr_hit[gi]),
            .strb_in    (w_strb_r),
            .wdata_in   (w_data_r),
            .value_out  (reg_val[gi])
         );

         fcr_rd_view u_view (
            .value_in   (reg_val[gi]),
            .sel_in     (rd_hit[gi]),
            .view_out   (rd_view[gi])
         );
      end
   endgenerate

   wire logic                 wr_mapped;
   wire logic                 rd_mapped;
   logic [`FCR_DATA_W-1:0]    rd_mux;

   assign wr_mapped = |wr_hit;
   assign rd_mapped = |rd_hit;

   always_comb begin
      rd_mux = '0;
      for (int i = 0; i < `FCR_NUM_REGS; i++) begin
         rd_mux = rd_mux | rd_view[i];
      end
   end

   // ----------------------------------------
   // write address and data capture
   // ----------------------------------------
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         aw_got_r <= 1'b0;
         aw_idx_r <= '0;
      end else if (aw_hs) begin
         aw_got_r <= 1'b1;
         aw_idx_r <= s_axi_awaddr_in[`FCR_IDX_MSB:`FCR_IDX_LSB];
      end else if (do_write) begin
         aw_got_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         w_got_r  <= 1'b0;
         w_data_r <= '0;
         w_strb_r <= '0;
      end else if (w_hs) begin
         w_got_r  <= 1'b1;
         w_data_r <= s_axi_wdata_in[`FCR_REG_W-1:0];
         w_strb_r <= s_axi_wstrb_in[1:0];
      end else if (do_write) begin
         w_got_r  <= 1'b0;
      end
   end

   // ----------------------------------------
   // write response
   // ----------------------------------------
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         bvalid_r <= 1'b0;
         bresp_r  <= `FCR_RESP_OKAY;
      end else if (do_write) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_mapped ? `FCR_RESP_OKAY : `FCR_RESP_SLVERR;
      end else if (b_hs) begin
         bvalid_r <= 1'b0;
      end
   end

   assign s_axi_bvalid_out = bvalid_r;
   assign s_axi_bresp_out  = bresp_r;

   // ----------------------------------------
   // read response
   // ----------------------------------------
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rresp_r  <= `FCR_RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_mux;
         rresp_r  <= rd_mapped ? `FCR_RESP_OKAY : `FCR_RESP_SLVERR;
      end else if (r_hs) begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_rvalid_out = rvalid_r;
   assign s_axi_rdata_out  = rdata_r;
   assign s_axi_rresp_out  = rresp_r;

   // ----------------------------------------
   // coefficients to the filters
   // ----------------------------------------
   fcr_coeff_bus_s coeff_r;
   fcr_coeff_bus_s coeff_nxt;

   // stored bits 11:0, msb included, feed tap nine and, in dual mode, the b taps
   assign coeff_nxt.a_tap9 = fcr_coeff_t'(reg_val[0][`FCR_COEF_MSB:0]);
   assign coeff_nxt.b_tap1 = dual_mode_in
                             ? fcr_coeff_t'(reg_val[1][`FCR_COEF_MSB:0]) : '0;
   assign coeff_nxt.b_tap2 = dual_mode_in
                             ? fcr_coeff_t'(reg_val[2][`FCR_COEF_MSB:0]) : '0;
   assign coeff_nxt.b_tap3 = dual_mode_in
                             ? fcr_coeff_t'(reg_val[3][`FCR_COEF_MSB:0]) : '0;
   assign coeff_nxt.b_tap4 = dual_mode_in
                             ? fcr_coeff_t'(reg_val[4][`FCR_COEF_MSB:0]) : '0;

   // 12-bit taps here; the 18-bit center tap lives elsewhere
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         coeff_r <= '0;
      end else if (ce_in) begin
         coeff_r <= coeff_nxt;
      end
   end

   assign coeff_out = coeff_r;

   // ----------------------------------------
   // unused inputs
   // ----------------------------------------
   wire logic unused_ok;
   assign unused_ok = ^{s_axi_awprot_in, s_axi_arprot_in,
                        s_axi_wdata_in[`FCR_DATA_W-1:`FCR_REG_W],
                        s_axi_wstrb_in[`FCR_STRB_W-1:2],
                        s_axi_awaddr_in[1:0], s_axi_araddr_in[1:0]};
endmodule

// File: rtl/fcr_regs.svh
// Purpose: register map and field constants of the coefficient bank
// Assumes: 32-bit register bus, one aligned word per register
// Notes:   printed offsets are word indices; byte address is index times four
`ifndef FCR_REGS_SVH
`define FCR_REGS_SVH

// ----------------------------------------
// bus geometry
// ----------------------------------------
`define FCR_ADDR_W      13
`define FCR_DATA_W      32
`define FCR_STRB_W      4
`define FCR_IDX_W       11
`define FCR_IDX_LSB     2
`define FCR_IDX_MSB     12

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define FCR_NUM_REGS    5
`define FCR_IDX_A_TAP9  11'h429
`define FCR_IDX_B_TAP1  11'h448
`define FCR_IDX_B_TAP2  11'h44a
`define FCR_IDX_B_TAP3  11'h44c
`define FCR_IDX_B_TAP4  11'h44e

// ----------------------------------------
// field layout
// ----------------------------------------
`define FCR_REG_W       16
`define FCR_COEF_W      12
`define FCR_COEF_MSB    11
`define FCR_RSVD_MSB    15
`define FCR_RSVD_LSB    12
`define FCR_LANE_W      8
`define FCR_REG_RESET   16'h0000
`define FCR_CENTER_W    18
`define FCR_NUM_TAPS    9

// ----------------------------------------
// bus responses
// ----------------------------------------
`define FCR_RESP_OKAY   2'h0
`define FCR_RESP_SLVERR 2'h2

`endif

// File: rtl/fcr_pkg.sv
// Purpose: shared types of the coefficient bank
// Assumes: constants come from fcr_regs.svh
// Notes:   types only
`include "fcr_regs.svh"
package fcr_pkg;
   typedef logic [`FCR_REG_W-1:0]          fcr_reg_t;
   typedef logic signed [`FCR_COEF_W-1:0]  fcr_coeff_t;
   typedef logic signed [`FCR_CENTER_W-1:0] fcr_center_t;
   typedef logic [`FCR_IDX_W-1:0]          fcr_idx_t;

   // ----------------------------------------
   // coefficients handed to the filters
   // ----------------------------------------
   typedef struct packed {
      fcr_coeff_t a_tap9;
      fcr_coeff_t b_tap1;
      fcr_coeff_t b_tap2;
      fcr_coeff_t b_tap3;
      fcr_coeff_t b_tap4;
   } fcr_coeff_bus_s;
endpackage

// File: rtl/fcr_coeff_reg.sv
// Purpose: one 16-bit coefficient register with byte-lane writes
// Assumes: write strobe qualified by caller
// Notes:   reserved bits are stored like the coefficient
`timescale 1ns/1ps
`include "fcr_regs.svh"
module fcr_coeff_reg
   import fcr_pkg::*;
(
   // clock and reset
   input  wire logic                 sys_clk_in,
   input  wire logic                 rst_in,
   input  wire logic                 ce_in,
   // write port
   input  wire logic                 we_in,
   input  wire logic [1:0]           strb_in,
   input  wire fcr_reg_t             wdata_in,
   // stored value
   output fcr_reg_t                  value_out
);
   fcr_reg_t value_r;
   fcr_reg_t value_nxt;

   // ----------------------------------------
   // byte-lane merge
   // ----------------------------------------
   assign value_nxt = {strb_in[1] ? wdata_in[`FCR_REG_W-1:`FCR_LANE_W]
                                  : value_r[`FCR_REG_W-1:`FCR_LANE_W],
                       strb_in[0] ? wdata_in[`FCR_LANE_W-1:0]
                                  : value_r[`FCR_LANE_W-1:0]};

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         value_r <= `FCR_REG_RESET;
      end else if (ce_in && we_in) begin
         value_r <= value_nxt;
      end
   end

   assign value_out = value_r;
endmodule

// File: rtl/fcr_rd_view.sv
// Purpose: readback view of one coefficient register
// Assumes: none
// Notes:   coefficient msb reads as zero, upper word reads as zero
`timescale 1ns/1ps
`include "fcr_regs.svh"
module fcr_rd_view
   import fcr_pkg::*;
(
   // stored value and select
   input  wire fcr_reg_t                 value_in,
   input  wire logic                     sel_in,
   // bus view
   output logic [`FCR_DATA_W-1:0]        view_out
);
   wire fcr_reg_t masked;

   // ----------------------------------------
   // msb forced low on read only
   // ----------------------------------------
   assign masked = {value_in[`FCR_RSVD_MSB:`FCR_RSVD_LSB], 1'b0,
                    value_in[`FCR_COEF_MSB-1:0]};
   assign view_out = sel_in ? {{(`FCR_DATA_W-`FCR_REG_W){1'b0}}, masked}
                            : '0;
endmodule

// File: test/fcr_top_sva.sv
// Purpose: port checks of the coefficient bank
// Assumes: ce_in stays high around write handshakes
// Notes:   bound to fcr_top from the bench top file
`timescale 1ns/1ps
`include "fcr_regs.svh"
module fcr_top_chk
   import fcr_pkg::*;
(
   // clock and reset
   input  wire logic                   sys_clk_in,
   input  wire logic                   rst_in,
   input  wire logic                   ce_in,
   // bus
   input  wire logic                   s_axi_awvalid_in,
   input  wire logic                   s_axi_awready_out,
   input  wire logic                   s_axi_wvalid_in,
   input  wire logic                   s_axi_wready_out,
   input  wire logic                   s_axi_bvalid_out,
   input  wire logic                   s_axi_bready_in,
   input  wire logic [1:0]             s_axi_bresp_out,
   input  wire logic                   s_axi_arvalid_in,
   input  wire logic                   s_axi_arready_out,
   input  wire logic                   s_axi_rvalid_out,
   input  wire logic                   s_axi_rready_in,
   input  wire logic [`FCR_DATA_W-1:0] s_axi_rdata_out,
   // filter side
   input  wire logic                   dual_mode_in,
   input  wire fcr_coeff_bus_s         coeff_out
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   chk_rd_msb_zero: assert property (s_axi_rvalid_out |-> !s_axi_rdata_out[11])
      else $error("read data coefficient msb not zero");
   chk_rd_upper_zero: assert property (s_axi_rvalid_out |-> !(|s_axi_rdata_out[31:16]))
      else $error("read data upper half not zero");
   chk_b_single_zero: assert property (ce_in && !dual_mode_in |=>
      {coeff_out.b_tap1, coeff_out.b_tap2, coeff_out.b_tap3, coeff_out.b_tap4} == 48'h0)
      else $error("channel b taps not zero in single mode");
   chk_a9_after_wr: assert property ($changed(coeff_out.a_tap9) |-> $past(s_axi_bvalid_out))
      else $error("tap nine changed without a write");
   chk_r_stands: assert property (s_axi_rvalid_out && !(s_axi_rready_in && ce_in)
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read answer dropped or changed");
   chk_b_stands: assert property (s_axi_bvalid_out && !(s_axi_bready_in && ce_in)
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
      else $error("write answer dropped or changed");
   chk_rd_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read answer late");
   chk_wr_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
      && s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out)
      else $error("write answer late");
   chk_ce_freeze: assert property (!ce_in |->
      !(s_axi_awready_out || s_axi_wready_out || s_axi_arready_out))
      else $error("ready high while clock enable low");
endmodule

// File: test/fcr_top_tb.sv
// Purpose: bus-level test of the coefficient bank
// Assumes: byte address is four times the register index
// Notes:   all five registers, strobes, unmapped word, stalls
`timescale 1ns/1ps
module fcr_top_tb
   import fcr_pkg::*;
;
   logic           sys_clk_in = 1'b0;
   logic           rst_in = 1'b1;
   logic           ce_in = 1'b1;
   logic           dual_mode_in = 1'b1;
   logic           s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
   logic           s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
   logic [2:0]     s_axi_awprot_in = 3'h0, s_axi_arprot_in = 3'h0;
   logic [12:0]    s_axi_awaddr_in = 13'h0, s_axi_araddr_in = 13'h0;
   logic [31:0]    s_axi_wdata_in = 32'h0;
   logic [3:0]     s_axi_wstrb_in = 4'h0;
   logic           s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
   logic           s_axi_arready_out, s_axi_rvalid_out;
   logic [1:0]     s_axi_bresp_out, s_axi_rresp_out;
   logic [31:0]    s_axi_rdata_out;
   fcr_coeff_bus_s coeff_out;
   int             miscompares = 0;
   int             comparisons = 0;
   int             stall = 0;
   logic [12:0]    addr_q [5] = '{13'h10a4, 13'h1120, 13'h1128, 13'h1130, 13'h1138};
   logic [15:0]    val_q [5] = '{16'hfabc, 16'h0801, 16'h1fff, 16'h8800, 16'h07ff};
   fcr_top dut_u (.*);
   always #12.5 sys_clk_in = ~sys_clk_in;
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic report_and_stop();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tmo(input int n);
      if (n >= 40) begin
         miscompares++;
         report_and_stop();
      end
   endtask
   task automatic wr(input logic [12:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      int   n;
      logic ta, tw, ga, gw;
      @(posedge sys_clk_in);
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= d;
      s_axi_wstrb_in <= s;
      n = 0;
      ta = 1'b0;
      tw = 1'b0;
      do begin
         @(negedge sys_clk_in);
         ga = s_axi_awready_out;
         gw = s_axi_wready_out;
         @(posedge sys_clk_in);
         if (ga === 1'b1) s_axi_awvalid_in <= 1'b0;
         if (gw === 1'b1) s_axi_wvalid_in <= 1'b0;
         ta |= (ga === 1'b1);
         tw |= (gw === 1'b1);
         n++;
      end while (!(ta && tw) && n < 40);
      repeat (stall) @(posedge sys_clk_in);
      s_axi_bready_in <= 1'b1;
      do begin
         @(negedge sys_clk_in);
         n++;
      end while (s_axi_bvalid_out !== 1'b1 && n < 40);
      chk("bresp", 64'(er), 64'(s_axi_bresp_out));
      tmo(n);
      @(posedge sys_clk_in);
      s_axi_bready_in <= 1'b0;
   endtask
   task automatic rd(input logic [12:0] a, input logic [63:0] e, input logic [1:0] er);
      int   n;
      logic g;
      @(posedge sys_clk_in);
      s_axi_arvalid_in <= 1'b1;
      s_axi_araddr_in <= a;
      n = 0;
      do begin
         @(negedge sys_clk_in);
         g = s_axi_arready_out;
         @(posedge sys_clk_in);
         n++;
      end while (g !== 1'b1 && n < 40);
      s_axi_arvalid_in <= 1'b0;
      repeat (stall) @(posedge sys_clk_in);
      s_axi_rready_in <= 1'b1;
      do begin
         @(negedge sys_clk_in);
         n++;
      end while (s_axi_rvalid_out !== 1'b1 && n < 40);
      chk("rdata", e, 64'(s_axi_rdata_out));
      chk("rresp", 64'(er), 64'(s_axi_rresp_out));
      tmo(n);
      @(posedge sys_clk_in);
      s_axi_rready_in <= 1'b0;
   endtask
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      @(negedge sys_clk_in);
      chk("coeff reset", 64'h0, 64'(coeff_out));
      chk("tap width", 64'hc, 64'($bits(coeff_out.a_tap9)));
      chk("tap bus width", 64'h3c, 64'($bits(coeff_out)));
      for (int i = 0; i < 5; i++) rd(addr_q[i], 64'h0, 2'h0);
      rd(13'h10a8, 64'h0, 2'h2);
      wr(13'h10a8, 32'h0000_0fff, 4'hf, 2'h2);
      for (int i = 0; i < 5; i++) wr(addr_q[i], {16'hdead, val_q[i]}, 4'hf, 2'h0);
      stall = 2;
      for (int i = 0; i < 5; i++) rd(addr_q[i], 64'(val_q[i] & 16'hf7ff), 2'h0);
      @(negedge sys_clk_in);
      chk("coeff dual", 64'({val_q[0][11:0], val_q[1][11:0], val_q[2][11:0],
          val_q[3][11:0], val_q[4][11:0]}), 64'(coeff_out));
      @(posedge sys_clk_in);
      dual_mode_in <= 1'b0;
      repeat (2) @(negedge sys_clk_in);
      chk("coeff single", 64'({val_q[0][11:0], 48'h0}), 64'(coeff_out));
      wr(addr_q[1], 32'h0000_5555, 4'h1, 2'h0);
      rd(addr_q[1], 64'h0055, 2'h0);
      wr(addr_q[3], 32'h0000_7733, 4'h2, 2'h0);
      rd(addr_q[3], 64'h7700, 2'h0);
      @(posedge sys_clk_in);
      ce_in <= 1'b0;
      repeat (3) @(negedge sys_clk_in);
      chk("arready frozen", 64'h0, 64'(s_axi_arready_out));
      @(posedge sys_clk_in);
      ce_in <= 1'b1;
      rst_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      rd(addr_q[0], 64'h0, 2'h0);
      report_and_stop();
   end
endmodule

bind fcr_top fcr_top_chk chk_u (.*);
